// file: hdl/eqs_map.svh
// constants of the egress queue scheduler and shaper
// assumes one 40 MHz clock; included by the package and the modules
`ifndef EQS_MAP_SVH
`define EQS_MAP_SVH
`define EQS_NQ 8
`define EQS_RATE_RST 20'h001f4
`define EQS_KBPS_MIN 20'h00064
`define EQS_KBPS_MAX 20'hf4240
`define EQS_MBPS_MIN 20'h00001
`define EQS_MBPS_MAX 20'h00ce4
`define EQS_WEIGHT_RST 7'h11
`define EQS_WEIGHT_MIN 20'h00001
`define EQS_WEIGHT_MAX 20'h00064
`define EQS_PCT_FULL 14'h0064
`define EQS_ML_PER_MBPS 22'h0003e8
`define EQS_ML_PER_BYTE 34'h0000001f40
`define EQS_BURST_ML 34'h0000f42400
`define EQS_CLK_NS 25
`define EQS_TICK_NS 1000
`define EQS_TICK_CYC ((`EQS_TICK_NS + `EQS_CLK_NS - 1) / `EQS_CLK_NS)
`define EQS_TGT_POL 2'h0
`define EQS_TGT_SHP 2'h1
`define EQS_TGT_PORT 2'h2
`define EQS_TGT_WGT 2'h3
`endif

// file: hdl/eqs_pkg.sv
// types shared by the scheduler, its buckets and the percent unit
// assumes eqs_map.svh is on the include path
`include "eqs_map.svh"
package eqs_pkg;
  typedef logic signed [33:0] eqs_cred_t; // millibits
  typedef logic [21:0] eqs_rate_t; // millibits per microsecond
  typedef enum logic [1:0] {SCH_IDLE = 2'b01, SCH_GAP = 2'b10} eqs_sch_e;
  typedef enum logic [1:0] {
    TGT_POL = `EQS_TGT_POL, TGT_SHP = `EQS_TGT_SHP,
    TGT_PORT = `EQS_TGT_PORT, TGT_WGT = `EQS_TGT_WGT
  } eqs_tgt_e;
  typedef struct packed {
    logic en;
    logic mbps;
    logic [19:0] rate;
  } eqs_lim_s;
  typedef struct packed {
    eqs_lim_s pol;
    eqs_lim_s shp;
    logic excess;
    logic [6:0] weight;
  } eqs_qcfg_s;
  typedef struct packed {
    logic wr;
    eqs_tgt_e tgt;
    logic [2:0] idx;
    logic en;
    logic mbps;
    logic excess;
    logic [19:0] val;
  } eqs_cfg_s;
  localparam eqs_lim_s EQS_LIM_RST = '{en: 1'b0, mbps: 1'b0, rate: `EQS_RATE_RST};
  localparam eqs_qcfg_s EQS_QCFG_RST = '{pol: EQS_LIM_RST, shp: EQS_LIM_RST,
                                         excess: 1'b0, weight: `EQS_WEIGHT_RST};
endpackage

// file: hdl/eqs_bucket.sv
// one token bucket: refills each tick, debited per frame
// assumes tick and debit come from logic on the same clock
`include "eqs_map.svh"
module eqs_bucket import eqs_pkg::*; #(
  parameter eqs_cred_t CAP = `EQS_BURST_ML
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic en,
  input wire logic tick,
  input wire eqs_rate_t rate,
  // debit
  input wire logic debit,
  input wire eqs_cred_t cost,
  // status
  output logic ok
);
  typedef struct packed {
    eqs_cred_t credit;
  } eqs_bkt_s;
  eqs_bkt_s q, d;

  if (CAP <= 0) begin : g_chk
    $error("bucket cap must be positive");
  end

  // refill then debit; a disabled bucket sits full so enabling starts with a burst
  always_comb begin
    d = q;
    if (!en) begin
      d.credit = CAP;
    end else begin
      if (tick) begin
        d.credit = d.credit + $signed({12'h000, rate});
      end
      if (debit) begin
        d.credit = d.credit - cost;
      end
      if (d.credit > CAP) begin
        d.credit = CAP;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{credit: CAP};
    end else begin
      q <= d;
    end
  end

  // debt allowed: a frame may overdraw, the queue then waits for refill
  assign ok = !en || !q.credit[33];
endmodule // eqs_bucket

// file: hdl/eqs_pct.sv
// weight share in percent, one queue at a time by repeated subtraction
// assumes weights stay within 1..100, so the sum is never zero
`include "eqs_map.svh"
module eqs_pct import eqs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // weights and mode
  input wire logic [7:0][6:0] weight,
  input wire logic weighted,
  // result
  output logic [7:0][6:0] pct
);
  typedef struct packed {
    logic [2:0] idx;
    logic [13:0] rem;
    logic [6:0] quo;
    logic [7:0][6:0] pct;
  } eqs_pct_s;
  eqs_pct_s q, d;
  logic [13:0] sum;

  always_comb begin
    sum = '0;
    for (int i = 0; i < 8; i++) begin
      sum = sum + {7'h00, weight[i]};
    end
  end

  // at most 101 cycles per queue; a stale figure lasts one sweep after a change
  always_comb begin
    d = q;
    if (q.rem >= sum) begin
      d.rem = q.rem - sum;
      d.quo = q.quo + 7'h01;
    end else begin
      d.pct[q.idx] = weighted ? q.quo : 7'h00;
      d.idx = q.idx + 3'h1;
      d.rem = 14'({7'h00, weight[d.idx]} * `EQS_PCT_FULL);
      d.quo = 7'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pct = q.pct;
endmodule // eqs_pct

// file: hdl/eqs_top.sv
// egress scheduler of one port: queue policers, shapers, port shaper
// assumes fabric and transmitter run on clk; config comes as one-cycle writes
`include "eqs_map.svh"
module eqs_top import eqs_pkg::*; #(
  parameter int NQ = `EQS_NQ,
  parameter int TICK_CYC = `EQS_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire eqs_cfg_s cfg,
  input wire logic sched_weighted,
  output logic cfg_err,
  output logic [7:0][6:0] weight_pct,
  // ingress policing
  input wire logic in_valid,
  input wire logic [2:0] in_queue,
  input wire logic [15:0] in_len,
  output logic pol_pass,
  output logic pol_drop,
  output logic [2:0] pol_queue,
  // queue fabric
  input wire logic [7:0] q_valid,
  input wire logic [7:0][15:0] q_len,
  // transmitter
  input wire logic out_ready,
  output logic gnt,
  output logic [2:0] gnt_queue,
  output logic gnt_excess
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    eqs_qcfg_s [7:0] qc;
    eqs_lim_s port;
    logic wgt;
    logic [5:0] tick_cnt;
    logic tick;
    logic cfg_err;
    logic pol_pass;
    logic pol_drop;
    logic [2:0] pol_idx;
    logic [15:0] pol_len;
    eqs_sch_e st;
    logic gnt;
    logic [2:0] gnt_idx;
    logic [15:0] gnt_len;
    logic gnt_exc;
    logic [2:0] rr_ptr;
    logic [6:0] served;
  } eqs_st_s;

  localparam eqs_st_s ST_RST = '{
    qc: {8{EQS_QCFG_RST}}, port: EQS_LIM_RST, wgt: 1'b0, tick_cnt: 6'h00,
    tick: 1'b0, cfg_err: 1'b0, pol_pass: 1'b0, pol_drop: 1'b0, pol_idx: 3'h0,
    pol_len: 16'h0000, st: SCH_IDLE, gnt: 1'b0, gnt_idx: 3'h0,
    gnt_len: 16'h0000, gnt_exc: 1'b0, rr_ptr: 3'h0, served: 7'h00};

  eqs_st_s q, d;

  if (NQ != 8 || TICK_CYC < 1 || TICK_CYC > 64) begin : g_chk
    $error("eqs_top serves eight queues and a tick of 1..64 cycles");
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic rate_ok(logic mbps, logic [19:0] v);
    if (mbps) begin
      return v >= `EQS_MBPS_MIN && v <= `EQS_MBPS_MAX;
    end
    return v >= `EQS_KBPS_MIN && v <= `EQS_KBPS_MAX;
  endfunction

  // kbps equals millibits per microsecond, so only Mbps needs scaling
  function automatic eqs_rate_t to_ml(eqs_lim_s c);
    if (c.mbps) begin
      return 22'({2'b00, c.rate} * `EQS_ML_PER_MBPS);
    end
    return {2'b00, c.rate};
  endfunction

  function automatic eqs_cred_t cost_of(logic [15:0] len);
    return eqs_cred_t'({18'h00000, len} * `EQS_ML_PER_BYTE);
  endfunction

  // highest set bit, found flag on top
  function automatic logic [3:0] pick_hi(logic [7:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // first set bit at or after start, wrapping
  function automatic logic [3:0] pick_rr(logic [7:0] m, logic [2:0] start);
    logic [3:0] r;
    logic [2:0] k;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      k = start + 3'(i);
      if (m[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // token buckets: one policer and one shaper per queue, one for the port
  logic [7:0] pol_ok, shp_ok;
  logic port_ok_b;

  for (genvar i = 0; i < 8; i++) begin : g_q
    eqs_bucket u_pol (
      .clk(clk), .rstn(rstn), .en(q.qc[i].pol.en), .tick(q.tick),
      .rate(to_ml(q.qc[i].pol)),
      .debit(q.pol_pass && q.pol_idx == 3'(i)),
      .cost(cost_of(q.pol_len)), .ok(pol_ok[i]));
    eqs_bucket u_shp (
      .clk(clk), .rstn(rstn), .en(q.qc[i].shp.en), .tick(q.tick),
      .rate(to_ml(q.qc[i].shp)),
      .debit(q.gnt && q.gnt_idx == 3'(i)),
      .cost(cost_of(q.gnt_len)), .ok(shp_ok[i]));
  end

  eqs_bucket u_port (
    .clk(clk), .rstn(rstn), .en(q.port.en), .tick(q.tick), .rate(to_ml(q.port)),
    .debit(q.gnt), .cost(cost_of(q.gnt_len)), .ok(port_ok_b));

  logic [7:0][6:0] wvec;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wvec[i] = q.qc[i].weight;
    end
  end

  eqs_pct u_pct (
    .clk(clk), .rstn(rstn), .weight(wvec), .weighted(q.wgt), .pct(weight_pct));

  //////////////////////////////////////////////////////////////////////////////
  // eligibility: in-rate queues first, excess queues only on leftover bandwidth
  logic [7:0] elig_in, elig_ex, cand;
  logic port_ok, quota_left;
  logic [3:0] pick;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      elig_in[i] = q_valid[i] && shp_ok[i];
      elig_ex[i] = q_valid[i] && !shp_ok[i] && q.qc[i].excess;
    end
    cand = (|elig_in) ? elig_in : elig_ex;
    port_ok = port_ok_b;
    quota_left = q.served < q.qc[q.rr_ptr].weight;
    if (!q.wgt) begin
      pick = pick_hi(cand);
    end else if (cand[q.rr_ptr] && quota_left) begin
      pick = {1'b1, q.rr_ptr};
    end else begin
      pick = pick_rr(cand, q.rr_ptr + 3'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.tick = 1'b0;
    d.cfg_err = 1'b0;
    d.pol_pass = 1'b0;
    d.pol_drop = 1'b0;
    d.gnt = 1'b0;
    d.wgt = sched_weighted;
    d.tick_cnt = q.tick_cnt + 6'h01;
    if (q.tick_cnt == 6'(TICK_CYC - 1)) begin
      d.tick_cnt = 6'h00;
      d.tick = 1'b1;
    end
    // a refused write leaves the whole entry as it was
    if (cfg.wr) begin
      case (cfg.tgt)
        TGT_POL: begin
          if (rate_ok(cfg.mbps, cfg.val)) begin
            d.qc[cfg.idx].pol = '{en: cfg.en, mbps: cfg.mbps, rate: cfg.val};
          end else begin
            d.cfg_err = 1'b1;
          end
        end
        TGT_SHP: begin
          if (rate_ok(cfg.mbps, cfg.val)) begin
            d.qc[cfg.idx].shp = '{en: cfg.en, mbps: cfg.mbps, rate: cfg.val};
            d.qc[cfg.idx].excess = cfg.excess;
          end else begin
            d.cfg_err = 1'b1;
          end
        end
        TGT_PORT: begin
          if (rate_ok(cfg.mbps, cfg.val)) begin
            d.port = '{en: cfg.en, mbps: cfg.mbps, rate: cfg.val};
          end else begin
            d.cfg_err = 1'b1;
          end
        end
        TGT_WGT: begin
          if (cfg.val >= `EQS_WEIGHT_MIN && cfg.val <= `EQS_WEIGHT_MAX) begin
            d.qc[cfg.idx].weight = cfg.val[6:0];
          end else begin
            d.cfg_err = 1'b1;
          end
        end
        default: d.cfg_err = 1'b1;
      endcase
    end
    // ingress policing: the bucket is debited the cycle after the pass
    if (in_valid) begin
      d.pol_idx = in_queue;
      d.pol_len = in_len;
      if (pol_ok[in_queue]) begin
        d.pol_pass = 1'b1;
      end else begin
        d.pol_drop = 1'b1;
      end
    end
    // one grant, then a gap so the buckets see the debit before the next pick
    case (q.st)
      SCH_IDLE: begin
        if (out_ready && port_ok && pick[3]) begin
          d.gnt = 1'b1;
          d.gnt_idx = pick[2:0];
          d.gnt_len = q_len[pick[2:0]];
          d.gnt_exc = !(|elig_in);
          d.st = SCH_GAP;
          // a queue that spent its quota and wins again alone starts a fresh turn
          if (pick[2:0] == q.rr_ptr && quota_left) begin
            d.served = q.served + 7'h01;
          end else begin
            d.rr_ptr = pick[2:0];
            d.served = 7'h01;
          end
        end
      end
      SCH_GAP: d.st = SCH_IDLE;
      default: d.st = SCH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cfg_err = q.cfg_err;
  assign pol_pass = q.pol_pass;
  assign pol_drop = q.pol_drop;
  assign pol_queue = q.pol_idx;
  assign gnt = q.gnt;
  assign gnt_queue = q.gnt_idx;
  assign gnt_excess = q.gnt_exc;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [7:0] above;
  assign above = 8'hfe << q.gnt_idx;

  sp_highest_a: assert property (
    gnt && !$past(q.wgt) |-> ($past(cand) & above) == 8'h00)
    else $error("strict priority granted below a waiting queue");

  pol_range_a: assert property (
    cfg.wr && cfg.tgt == TGT_POL && !cfg.mbps && cfg.val > `EQS_KBPS_MAX
    |=> cfg_err && q.qc[$past(cfg.idx)].pol == $past(q.qc[cfg.idx].pol))
    else $error("out of range policer rate was taken");

  shp_write_a: assert property (
    cfg.wr && cfg.tgt == TGT_SHP && rate_ok(cfg.mbps, cfg.val)
    |=> !cfg_err && q.qc[$past(cfg.idx)].shp.rate == $past(cfg.val))
    else $error("valid shaper rate not stored");

  pol_off_a: assert property (
    in_valid && !q.qc[in_queue].pol.en |=> pol_pass && !pol_drop)
    else $error("disabled policer limited traffic");

  // the index comes from the decision cycle, where d already carries the granted queue
  shp_gate_a: assert property (
    gnt |-> $past(shp_ok[d.gnt_idx]) || $past(q.qc[d.gnt_idx].excess) && gnt_excess)
    else $error("shaped queue sent without credit or excess");

  port_gate_a: assert property (
    gnt |-> $past(port_ok) ##1 !gnt)
    else $error("grant without port credit or back to back");

  work_cons_a: assert property (
    q.st == SCH_IDLE && out_ready && port_ok && |cand |=> gnt)
    else $error("eligible traffic held back");

  weight_rng_a: assert property (
    q.qc[q.rr_ptr].weight >= 7'h01 && q.qc[q.rr_ptr].weight <= 7'h64)
    else $error("weight left its range");

  wrr_quota_a: assert property (
    gnt && q.wgt && $past(q.wgt) |-> q.served <= q.qc[q.rr_ptr].weight)
    else $error("queue served past its weight");

  // write paths, policer verdict, excess order and the refill tick
  pol_drop_a: assert property (
    in_valid && q.qc[in_queue].pol.en && !pol_ok[in_queue] |=> pol_drop && !pol_pass)
    else $error("policer passed a frame without credit");

  pol_unit_a: assert property (
    cfg.wr && cfg.tgt == TGT_POL && rate_ok(cfg.mbps, cfg.val)
    |=> q.qc[$past(cfg.idx)].pol.mbps == $past(cfg.mbps))
    else $error("policer unit not stored");

  port_range_a: assert property (
    cfg.wr && cfg.tgt == TGT_PORT && !rate_ok(cfg.mbps, cfg.val)
    |=> cfg_err && q.port == $past(q.port))
    else $error("out of range port shaper rate was taken");

  port_unit_a: assert property (
    cfg.wr && cfg.tgt == TGT_PORT && rate_ok(cfg.mbps, cfg.val)
    |=> q.port.mbps == $past(cfg.mbps) && q.port.rate == $past(cfg.val))
    else $error("port shaper setting not stored");

  wgt_write_a: assert property (
    cfg.wr && cfg.tgt == TGT_WGT && cfg.val >= `EQS_WEIGHT_MIN && cfg.val <= `EQS_WEIGHT_MAX
    |=> !cfg_err && q.qc[$past(cfg.idx)].weight == $past(cfg.val[6:0]))
    else $error("valid weight not stored");

  exc_last_a: assert property (
    gnt && gnt_excess |-> $past(elig_in) == 8'h00)
    else $error("excess grant while an in-rate queue waited");

  tick_cnt_a: assert property (
    {1'b0, q.tick_cnt} < 7'(TICK_CYC))
    else $error("tick counter ran past its period");

  cov_sp_c: cover property (gnt && !q.wgt ##2 gnt && !q.wgt);
  cov_wrr_c: cover property (gnt && q.wgt ##2 gnt && q.wgt && $changed(gnt_queue));
  cov_exc_c: cover property (gnt && gnt_excess);
  cov_drop_c: cover property (pol_drop);
endmodule // eqs_top

// file: sim/eqs_far.sv
// fabric and transmitter model: per-queue frame counts, granted head frames leave
// assumes the bench loads counts with a one-cycle pulse; every frame is 2000 bytes
module eqs_far import eqs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench control
  input wire logic ld,
  input wire logic [7:0][3:0] ld_n,
  input wire logic stall,
  // scheduler side
  input wire logic gnt,
  input wire logic [2:0] gnt_queue,
  output logic [7:0] q_valid,
  output logic [7:0][15:0] q_len,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0][4:0] cnt_q;
  logic [15:0] junk_q;
  //////////////////////////////////////////////////////////////////////////////
  // head frame leaves at the grant edge, so it is gone before the next decision
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      junk_q <= 16'h0000;
    end else begin
      junk_q <= ~junk_q + 16'h1357;
      for (int i = 0; i < 8; i++) begin
        cnt_q[i] <= cnt_q[i] + (ld ? 5'(ld_n[i]) : 5'h00)
                    - ((gnt && gnt_queue == 3'(i)) ? 5'h01 : 5'h00);
      end
    end
  end
  // an empty queue shows a moving length, never a stale one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      q_valid[i] = (cnt_q[i] != 5'h00);
      q_len[i] = q_valid[i] ? 16'h07d0 : junk_q;
    end
  end
  // transmitter stalls at random so grants meet a slow sink too
  assign out_ready = !stall;
endmodule // eqs_far

// file: sim/eqs_top_bench.sv
// self-checking bench: config table, policing, strict, weighted, shapers
// assumes eqs_far as the fabric and transmitter; short tick for brief refills
module eqs_top_bench import eqs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 2;
  // tgt, mbps, expected refusal, value
  localparam logic [23:0] TAB [14] = '{24'h100063, 24'h000064, 24'h0f4240, 24'h1f4241,
    24'h300000, 24'h200001, 24'h200ce4, 24'h300ce5, 24'h500032, 24'hb00ce5,
    24'hd00000, 24'hd00065, 24'hc00064, 24'hc00011};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  eqs_cfg_s cfg = '0;
  logic sched_weighted = 1'b0, in_valid = 1'b0, stall = 1'b0, ld = 1'b0;
  logic [2:0] in_queue = 3'h0;
  logic [15:0] in_len = 16'h0000;
  logic [7:0][3:0] ld_n = '0;
  logic cfg_err, pol_pass, pol_drop, gnt, gnt_excess, out_ready;
  logic [2:0] pol_queue, gnt_queue;
  logic [7:0] q_valid;
  logic [7:0][15:0] q_len;
  logic [7:0][6:0] weight_pct;
  logic [31:0] seed = 32'h17f25945;
  logic [4:0] pol_exp[$];
  logic [3:0] gnt_exp[$];
  int wcnt[8];
  int fail_count = 0;
  int compares = 0;
  //////////////////////////////////////////////////////////////////////////////
  eqs_top #(.TICK_CYC(TICK)) DUT (.clk(clk), .rstn(rstn), .cfg(cfg),
    .sched_weighted(sched_weighted), .cfg_err(cfg_err), .weight_pct(weight_pct),
    .in_valid(in_valid), .in_queue(in_queue), .in_len(in_len), .pol_pass(pol_pass),
    .pol_drop(pol_drop), .pol_queue(pol_queue), .q_valid(q_valid), .q_len(q_len),
    .out_ready(out_ready), .gnt(gnt), .gnt_queue(gnt_queue), .gnt_excess(gnt_excess));
  eqs_far far_end (.clk(clk), .rstn(rstn), .ld(ld), .ld_n(ld_n), .stall(stall),
    .gnt(gnt), .gnt_queue(gnt_queue), .q_valid(q_valid), .q_len(q_len),
    .out_ready(out_ready));
  //////////////////////////////////////////////////////////////////////////////
  // clock and random sink stalls
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    seed <= lfsr(seed);
    stall <= seed[0] & seed[3];
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one-cycle write; the refusal flag answers in the cycle after the taking edge
  task automatic cfg_wr(input eqs_tgt_e t, input logic [2:0] i, input logic e, m, x,
                        input logic [19:0] v, input logic err);
    @(posedge clk);
    cfg <= '{wr: 1'b1, tgt: t, idx: i, en: e, mbps: m, excess: x, val: v};
    @(posedge clk);
    cfg.wr <= 1'b0;
    #1 chk(cfg_err, err);
  endtask
  task automatic pol(input logic [2:0] q, input logic [15:0] len, input logic pass);
    @(posedge clk);
    in_valid <= 1'b1;
    in_queue <= q;
    in_len <= len;
    pol_exp.push_back({~pass, pass, q});
  endtask
  task automatic idle;
    @(posedge clk);
    in_valid <= 1'b0;
  endtask
  task automatic load(input logic [7:0][3:0] n);
    @(posedge clk);
    ld <= 1'b1;
    ld_n <= n;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  // bounded wait for noted grants, and optionally for empty queues
  task automatic drain(input logic all);
    for (int n = 0; gnt_exp.size() > 0 || (all && q_valid !== 8'h00); n++) begin
      if (n > 4000) begin
        fail_count++;
        end_sim();
      end
      @(posedge clk);
    end
  endtask
  // results land between edges; the oldest note is taken and compared
  always @(negedge clk) begin
    if (pol_pass === 1'b1 || pol_drop === 1'b1) begin
      if (pol_exp.size() == 0) chk(1, 0);
      else chk({pol_drop, pol_pass, pol_queue}, pol_exp.pop_front());
    end
    if (gnt === 1'b1) begin
      if (gnt_exp.size() > 0) chk({gnt_excess, gnt_queue}, gnt_exp.pop_front());
      else wcnt[gnt_queue]++;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk(weight_pct, '0);
    foreach (TAB[k]) cfg_wr(eqs_tgt_e'(TAB[k][23:22]), 3'h6, 1'b0, TAB[k][21], 1'b0,
                            TAB[k][19:0], TAB[k][20]);
    // enabled policer: both back-to-back frames see full credit, a later one is dropped
    cfg_wr(TGT_POL, 3'h3, 1'b1, 1'b0, 1'b0, 20'h00064, 1'b0);
    pol(3'h3, 16'h07d0, 1'b1);
    pol(3'h3, 16'h07d0, 1'b1);
    idle();
    idle();
    pol(3'h3, 16'h07d0, 1'b0);
    idle();
    // Mbps unit: the same debt refills within a few ticks, a kbps bucket would still owe
    cfg_wr(TGT_POL, 3'h2, 1'b1, 1'b1, 1'b0, 20'h00ce4, 1'b0);
    pol(3'h2, 16'h07d0, 1'b1);
    pol(3'h2, 16'h07d0, 1'b1);
    idle();
    idle();
    pol(3'h2, 16'h07d0, 1'b0);
    repeat (30) idle();
    pol(3'h2, 16'h07d0, 1'b1);
    for (int k = 0; k < 4; k++) pol(3'h4, seed[15:0] | 16'h0040, 1'b1);
    repeat (3) idle();
    chk(pol_exp.size(), 0);
    // strict: the top queue is emptied before lower ones are touched
    gnt_exp = '{4'h7, 4'h7, 4'h7, 4'h3, 4'h0};
    load(32'h30001001);
    drain(1);
    // weighted: percent shares, then rotation split by weight
    sched_weighted <= 1'b1;
    repeat (900) @(posedge clk);
    #1 chk(weight_pct[7], 7'h0c);
    cfg_wr(TGT_WGT, 3'h1, 1'b0, 1'b0, 1'b0, 20'h00002, 1'b0);
    cfg_wr(TGT_WGT, 3'h2, 1'b0, 1'b0, 1'b0, 20'h00001, 1'b0);
    repeat (900) @(posedge clk);
    #1 chk(weight_pct[1], 7'h01);
    chk(weight_pct[2], 7'h00);
    chk(weight_pct[0], 7'h10);
    wcnt = '{default: 0};
    load(32'h00000990);
    for (int n = 0; wcnt.sum() < 9 && n < 3000; n++) @(posedge clk);
    chk(wcnt[1], 6);
    chk(wcnt[2], 3);
    drain(1);
    // without congestion a lone queue flows freely
    gnt_exp = '{4'h6, 4'h6, 4'h6};
    load(32'h03000000);
    drain(1);
    // queue shaper: two frames drain the bucket, the third waits for excess
    sched_weighted <= 1'b0;
    cfg_wr(TGT_SHP, 3'h5, 1'b1, 1'b0, 1'b0, 20'h00064, 1'b0);
    gnt_exp = '{4'h5, 4'h5};
    load(32'h00300000);
    drain(0);
    wcnt = '{default: 0};
    repeat (200) @(posedge clk);
    chk(wcnt[5], 0);
    gnt_exp = '{4'hd};
    cfg_wr(TGT_SHP, 3'h5, 1'b1, 1'b0, 1'b1, 20'h00064, 1'b0);
    drain(1);
    // second reset, then port shaper caps the whole port
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cfg_wr(TGT_PORT, 3'h0, 1'b1, 1'b0, 1'b0, 20'h00064, 1'b0);
    gnt_exp = '{4'h0, 4'h0};
    load(32'h00000003);
    drain(0);
    wcnt = '{default: 0};
    repeat (200) @(posedge clk);
    chk(wcnt[0], 0);
    end_sim();
  end
endmodule // eqs_top_bench
